// ===== rtl/kb_support.sv
// keyboard support logic: view/hold timer, strobe repeat, click, bell, power-up pulses
// Functional notes
// R1: view key or restart request starts a 60 to 120 second viewing interval, hold off.
// R2: during viewing the warning counter stays cleared and no blink pulses occur.
// R3: after viewing, pulses run; each pulse trailing edge advances the 4-bit counter.
// R4: active-low lamp follows counter bit 0, blinking 7 times before counter is full.
// R5: full counter asserts hold low, stops pulses, drives view line to inverted level.
// R6: in hold the lamp output stays low until a new viewing interval.
// R7: terminal activity or a key press removes hold and restarts viewing; the code takes only the view key, restart request or activity.
// R8: without repeat key, keyboard strobe copies the raw key strobe.
// R9: a held character key without repeat keeps the keyboard strobe high.
// R10: repeat plus held key gives repeated keyboard strobe pulses.
// R11: repeat oscillator toggles a gate flip-flop, breaking the strobe at 10 Hz.
// R12: each strobe gating transition gives one positive click pulse of about 200 us; the code clicks only on strobe rising edges.
// R13: tone toggles always, reaching the speaker only while the bell sounds.
// R14: bell or ring request starts the tone, self-blocks, ends after half a second.
// R15: at power-up initial and active-low home assert, released about 100 ms later.
// R16: after power-up the home key produces a home signal.
// R17: all intervals come from clock-driven counters with lengths in parameters.
// R18: repeat rate is a parameter, default 10 Hz gating.
`timescale 1ns/1ns
module kb_support #(
    parameter int TICK_CYCLES_P    = kb_support_pkg::TICK_CYCLES,
    parameter int VIEW_MS_P        = kb_support_pkg::VIEW_MS,
    parameter int BLINK_MS_P       = kb_support_pkg::BLINK_MS,
    parameter int REPEAT_HALF_MS_P = kb_support_pkg::REPEAT_HALF_MS,
    parameter int CLICK_CYCLES_P   = kb_support_pkg::CLICK_CYCLES,
    parameter int BELL_MS_P        = kb_support_pkg::BELL_MS,
    parameter int POWERUP_MS_P     = kb_support_pkg::POWERUP_MS
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic raw_key_strobe_i,
    input  wire logic repeat_key_n_i,
    input  wire logic view_key_press_i,
    input  wire logic view_restart_n_i,
    input  wire logic terminal_activity_i,
    input  wire logic bell_request_n_i,
    input  wire logic ring_request_n_i,
    input  wire logic home_key_press_i,
    output logic      key_strobe_out_o,
    output logic      view_lamp_n_o,
    output logic      hold_n_o,
    output logic      view_o,
    output logic      click_o,
    output logic      speaker_out_o,
    output logic      initial_o,
    output logic      home_n_o
);
    import kb_support_pkg::*;

    // ------------------------------------------------------------
    // reset record and helpers
    // ------------------------------------------------------------
    localparam logic [TMR_W-1:0] VIEW_LOAD  = TMR_W'(VIEW_MS_P - 1);
    localparam logic [TMR_W-1:0] BLINK_LOAD = TMR_W'(BLINK_MS_P - 1);
    localparam logic [TMR_W-1:0] RPT_LOAD   = TMR_W'(REPEAT_HALF_MS_P - 1);
    localparam logic [TMR_W-1:0] CLICK_LOAD = TMR_W'(CLICK_CYCLES_P - 1);
    localparam logic [TMR_W-1:0] BELL_LOAD  = TMR_W'(BELL_MS_P - 1);
    localparam logic [TMR_W-1:0] PU_LOAD    = TMR_W'(POWERUP_MS_P - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO   = 17'h0_0000;

    localparam kb_state_t ST_RESET = '{
        s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, filt: PIN_IDLE,
        vstate: V_VIEW, view_tmr: VIEW_LOAD, blink_tmr: BLINK_LOAD,
        pulse: 1'b0, wcnt: 4'h0, view_prev: 1'b0, gate: 1'b1,
        rpt_tmr: RPT_LOAD, strobe: 1'b0, click: 1'b0, click_tmr: TMR_ZERO,
        tone: 1'b0, bell_on: 1'b0, bell_blk: 1'b0, bell_tmr: TMR_ZERO,
        pu: 1'b1, pu_tmr: PU_LOAD, lamp_n: 1'b1, hold_n: 1'b1,
        speaker: 1'b0, home_n: 1'b0
    };

    function automatic logic [TMR_W-1:0] dec(input logic [TMR_W-1:0] v);
        return v - 17'h0_0001;
    endfunction

    function automatic logic expired(input logic [TMR_W-1:0] v);
        return v == TMR_ZERO;
    endfunction

    kb_state_t        st_reg;
    kb_state_t        st_next;
    logic             tick;
    logic [PIN_N-1:0] pins;
    logic             view_req;
    logic             rpt_on;
    logic             bell_req;

    ms_tick_gen #(.DIV(TICK_CYCLES_P)) u_tick (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_o    (tick)
    );

    assign pins = {home_key_press_i, ring_request_n_i, bell_request_n_i,
                   view_restart_n_i, view_key_press_i, repeat_key_n_i, raw_key_strobe_i};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // three-stage pin synchronisers, change taken when stages 2 and 3 agree
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < PIN_N; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.filt[i] = st_reg.s3[i];
            end
        end

        // view / hold timer
        st_next.view_prev = st_reg.filt[PIN_VIEW];
        view_req = (st_reg.filt[PIN_VIEW] & ~st_reg.view_prev)
                 | ~st_reg.filt[PIN_RST_N] | terminal_activity_i;
        case (st_reg.vstate)
            V_VIEW: begin
                st_next.wcnt      = 4'h0; // R2
                st_next.pulse     = 1'b0; // R2
                st_next.blink_tmr = BLINK_LOAD;
                if (tick) begin
                    if (expired(st_reg.view_tmr)) begin
                        st_next.vstate = V_WARN; // R3
                    end else begin
                        st_next.view_tmr = dec(st_reg.view_tmr);
                    end
                end
            end
            V_WARN: begin
                if (tick) begin
                    if (st_reg.pulse) begin
                        st_next.pulse = 1'b0;
                        st_next.wcnt  = st_reg.wcnt + 4'h1; // R3
                        if (st_reg.wcnt + 4'h1 == WCNT_FULL) begin
                            st_next.vstate = V_HOLD; // R5
                        end
                    end else if (expired(st_reg.blink_tmr)) begin
                        st_next.pulse     = 1'b1;
                        st_next.blink_tmr = BLINK_LOAD;
                    end else begin
                        st_next.blink_tmr = dec(st_reg.blink_tmr);
                    end
                end
            end
            V_HOLD: begin
                st_next.pulse = 1'b0; // R5
            end
            default: begin
                st_next.vstate = V_VIEW;
            end
        endcase
        if (view_req) begin
            st_next.vstate   = V_VIEW; // R1
            st_next.view_tmr = VIEW_LOAD; // R7
            st_next.wcnt     = 4'h0;
            st_next.pulse    = 1'b0;
        end

        // strobe and repeat
        rpt_on = ~st_reg.filt[PIN_RPT_N] & st_reg.filt[PIN_RAW];
        if (!rpt_on) begin
            st_next.gate    = 1'b1; // R8
            st_next.rpt_tmr = RPT_LOAD;
        end else if (tick) begin
            if (expired(st_reg.rpt_tmr)) begin
                st_next.gate    = ~st_reg.gate; // R11
                st_next.rpt_tmr = RPT_LOAD; // R18
            end else begin
                st_next.rpt_tmr = dec(st_reg.rpt_tmr);
            end
        end
        st_next.strobe = st_reg.filt[PIN_RAW] & st_reg.gate; // R8 R9 R10

        // key click on each strobe start
        if (st_next.strobe && !st_reg.strobe) begin
            st_next.click     = 1'b1; // R12
            st_next.click_tmr = CLICK_LOAD;
        end else if (st_reg.click) begin
            if (expired(st_reg.click_tmr)) begin
                st_next.click = 1'b0;
            end else begin
                st_next.click_tmr = dec(st_reg.click_tmr);
            end
        end

        // bell tone and self-blocking gate
        st_next.tone = st_reg.tone ^ tick; // R13
        bell_req = ~st_reg.filt[PIN_BELL_N] | ~st_reg.filt[PIN_RING_N];
        if (st_reg.bell_on) begin
            if (tick) begin
                if (expired(st_reg.bell_tmr)) begin
                    st_next.bell_on = 1'b0; // R14
                end else begin
                    st_next.bell_tmr = dec(st_reg.bell_tmr);
                end
            end
        end else if (bell_req && !st_reg.bell_blk) begin
            st_next.bell_on  = 1'b1; // R14
            st_next.bell_blk = 1'b1;
            st_next.bell_tmr = BELL_LOAD;
        end else if (!bell_req) begin
            st_next.bell_blk = 1'b0;
        end

        // power-up interval
        if (st_reg.pu && tick) begin
            if (expired(st_reg.pu_tmr)) begin
                st_next.pu = 1'b0; // R15
            end else begin
                st_next.pu_tmr = dec(st_reg.pu_tmr);
            end
        end

        // registered outputs
        st_next.hold_n  = (st_next.vstate != V_HOLD); // R5
        st_next.lamp_n  = (st_next.vstate == V_HOLD) ? 1'b0 : ~st_next.wcnt[0]; // R4 R6
        st_next.speaker = (st_reg.tone & st_reg.bell_on) | st_reg.click; // R13
        st_next.home_n  = ~(st_next.pu | st_reg.filt[PIN_HOME]); // R15 R16
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign key_strobe_out_o = st_reg.strobe;
    assign view_lamp_n_o    = st_reg.lamp_n;
    assign hold_n_o         = st_reg.hold_n;
    assign view_o           = ~st_reg.hold_n; // R5
    assign click_o          = st_reg.click;
    assign speaker_out_o    = st_reg.speaker;
    assign initial_o        = st_reg.pu;
    assign home_n_o         = st_reg.home_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    chk_view_cleared: assert property ( // R2
        st_reg.vstate == V_VIEW |=> st_reg.vstate != V_WARN || st_reg.wcnt == 4'h0)
        else $error("warning counter moved during viewing");
    chk_count_step: assert property ( // R3
        st_reg.vstate == V_WARN && $past(st_reg.vstate) == V_WARN
        && st_reg.wcnt != $past(st_reg.wcnt) |-> st_reg.wcnt == $past(st_reg.wcnt) + 4'h1)
        else $error("warning counter did not step by one");
    chk_lamp_follow: assert property ( // R4
        st_reg.vstate == V_WARN && !view_req |=> view_lamp_n_o == ~st_reg.wcnt[0])
        else $error("lamp does not follow counter bit 0");
    chk_hold_entry: assert property ( // R5
        st_reg.wcnt == WCNT_FULL |-> st_reg.vstate == V_HOLD && !hold_n_o && view_o)
        else $error("full counter did not give hold");
    chk_hold_lamp: assert property ( // R6
        st_reg.vstate == V_HOLD && !view_req |=> !view_lamp_n_o && !st_reg.pulse)
        else $error("lamp not low in hold");
    chk_restart: assert property ( // R7
        terminal_activity_i |=> st_reg.vstate == V_VIEW ##1 hold_n_o)
        else $error("activity did not restart viewing");
    chk_strobe_copy: assert property ( // R8
        st_reg.filt[PIN_RPT_N] && $past(st_reg.filt[PIN_RPT_N]) |=>
        key_strobe_out_o == $past(st_reg.filt[PIN_RAW]))
        else $error("strobe not a copy of raw strobe");
    chk_click_width: assert property ( // R12
        $rose(click_o) |=> click_o [*8])
        else $error("click pulse too short");
    chk_bell_len: assert property ( // R14
        $rose(st_reg.bell_on) |=> st_reg.bell_on [*8] ##1 st_reg.bell_blk)
        else $error("bell ended early or unblocked");
    chk_speaker_gate: assert property ( // R13
        speaker_out_o |-> $past(st_reg.bell_on) || $past(st_reg.click))
        else $error("speaker driven without bell or click");
    chk_power_home: assert property ( // R15
        initial_o |-> !home_n_o)
        else $error("home not asserted with initial");
    chk_home_follow: assert property ( // R16
        !initial_o |-> home_n_o == !$past(st_reg.filt[PIN_HOME]))
        else $error("home output does not follow home key");
    chk_count_freeze: assert property ( // R5
        st_reg.vstate == V_HOLD && !view_req |=> st_reg.vstate == V_HOLD && st_reg.wcnt == WCNT_FULL)
        else $error("counter moved in hold");
    chk_gate_steady: assert property ( // R11
        rpt_on && !tick |=> st_reg.gate == $past(st_reg.gate))
        else $error("strobe gate toggled between oscillator pulses");
    chk_view_hold_off: assert property ( // R1
        st_reg.vstate == V_VIEW |-> hold_n_o && !view_o)
        else $error("hold asserted during viewing");

    // ------------------------------------------------------------
    // coverage of main scenarios
    // ------------------------------------------------------------
    cov_hold: cover property (st_reg.vstate == V_WARN ##1 st_reg.vstate == V_HOLD);
    cov_repeat: cover property (rpt_on && $changed(st_reg.gate));
    cov_bell: cover property ($fell(st_reg.bell_on));
    cov_click: cover property ($rose(click_o));
    cov_hold_exit: cover property (st_reg.vstate == V_HOLD ##1 st_reg.vstate == V_VIEW);

endmodule // kb_support

// ===== rtl/kb_support_pkg.sv
// shared constants, state encodings and state record of the keyboard support logic
package kb_support_pkg;

    // ------------------------------------------------------------
    // clock and interval figures
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int VIEW_MS        = 90_000;
    localparam int BLINK_MS       = 250;
    localparam int REPEAT_HALF_MS = 50;
    localparam int CLICK_US       = 200;
    localparam int CLICK_CYCLES   = CLICK_US * 1000 / CLK_PERIOD_NS;
    localparam int BELL_MS        = 500;
    localparam int POWERUP_MS     = 100;
    localparam int TMR_W          = 17;

    // ------------------------------------------------------------
    // pin input positions and idle levels
    // ------------------------------------------------------------
    localparam int PIN_N        = 7;
    localparam int PIN_RAW      = 0;
    localparam int PIN_RPT_N    = 1;
    localparam int PIN_VIEW     = 2;
    localparam int PIN_RST_N    = 3;
    localparam int PIN_BELL_N   = 4;
    localparam int PIN_RING_N   = 5;
    localparam int PIN_HOME     = 6;
    localparam logic [PIN_N-1:0] PIN_IDLE = 7'h3a;
    localparam logic [3:0] WCNT_FULL = 4'hf;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        V_VIEW = 3'b001,
        V_WARN = 3'b010,
        V_HOLD = 3'b100
    } view_state_t;

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        logic [PIN_N-1:0] filt;
        view_state_t      vstate;
        logic [TMR_W-1:0] view_tmr;
        logic [TMR_W-1:0] blink_tmr;
        logic             pulse;
        logic [3:0]       wcnt;
        logic             view_prev;
        logic             gate;
        logic [TMR_W-1:0] rpt_tmr;
        logic             strobe;
        logic             click;
        logic [TMR_W-1:0] click_tmr;
        logic             tone;
        logic             bell_on;
        logic             bell_blk;
        logic [TMR_W-1:0] bell_tmr;
        logic             pu;
        logic [TMR_W-1:0] pu_tmr;
        logic             lamp_n;
        logic             hold_n;
        logic             speaker;
        logic             home_n;
    } kb_state_t;

endpackage

// ===== rtl/ms_tick_gen.sv
// divider that gives a one-cycle enable once per interval tick
`timescale 1ns/1ns
module ms_tick_gen #(
    parameter int DIV = kb_support_pkg::TICK_CYCLES
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    output logic      tick_o
);
    import kb_support_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_state_t;

    tick_state_t st_reg;
    tick_state_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= 32'(DIV - 1)) begin
            st_next.cnt  = 32'h0000_0000;
            st_next.tick = 1'b1; // R17
        end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= '{cnt: 32'h0000_0000, tick: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;

endmodule // ms_tick_gen

// ===== tb/kb_far_side.sv
// far-side model: keyboard switches, terminal activity, lamp and speaker observers
`timescale 1ns/1ns
module kb_far_side (
    input  wire logic                            ref_clk_i,
    input  wire logic                            view_lamp_n_i,
    input  wire logic                            speaker_i,
    input  wire logic                            key_strobe_i,
    input  wire logic                            click_i,
    output logic [kb_support_pkg::PIN_N-1:0]     pins_o,
    output logic                                 act_o
);
    import kb_support_pkg::*;

    int   lamp_blinks;
    int   spk_edges;
    int   strobe_falls;
    int   strobe_rises;
    int   click_rises;
    logic lamp_q;
    logic spk_q;
    logic stb_q;
    logic clk_q;

    // ------------------------------------------------------------
    // switch levels, idle at start
    // ------------------------------------------------------------
    initial begin
        pins_o = PIN_IDLE;
        act_o  = 1'b0;
        lamp_q = 1'b1;
        spk_q  = 1'b0;
        stb_q  = 1'b0;
        clk_q  = 1'b0;
        clear_counts();
    end

    task automatic set_pin(input int idx, input logic v);
        @(negedge ref_clk_i);
        pins_o[idx] = v;
    endtask

    task automatic set_act(input logic v);
        @(negedge ref_clk_i);
        act_o = v;
    endtask

    task automatic clear_counts();
        lamp_blinks  = 0;
        spk_edges    = 0;
        strobe_falls = 0;
        strobe_rises = 0;
        click_rises  = 0;
    endtask

    // ------------------------------------------------------------
    // observers of lamp, speaker, strobe and click
    // ------------------------------------------------------------
    always @(negedge ref_clk_i) begin
        if (lamp_q === 1'b0 && view_lamp_n_i === 1'b1) lamp_blinks++;
        if (speaker_i !== spk_q) spk_edges++;
        if (stb_q === 1'b1 && key_strobe_i === 1'b0) strobe_falls++;
        if (stb_q === 1'b0 && key_strobe_i === 1'b1) strobe_rises++;
        if (clk_q === 1'b0 && click_i === 1'b1) click_rises++;
        lamp_q = view_lamp_n_i;
        spk_q  = speaker_i;
        stb_q  = key_strobe_i;
        clk_q  = click_i;
    end
endmodule // kb_far_side

// ===== tb/kb_support_bench.sv
// self-checking bench of the keyboard support logic
`timescale 1ns/1ns
module kb_support_bench;
    import kb_support_pkg::*;

    logic             ref_clk;
    logic             srst;
    logic [PIN_N-1:0] pins;
    logic             act;
    logic [7:0]       outs;
    int               errors;
    int               compares;

    // shortened intervals for simulation
    localparam int TICK_P   = 10;
    localparam int VIEW_P   = 20;
    localparam int BLINK_P  = 3;
    localparam int RPT_P    = 4;
    localparam int CLICK_P  = 12;
    localparam int BELL_P   = 10;
    localparam int PU_P     = 5;
    // cycles from a restart to hold: viewing, then fifteen counter steps
    localparam int HOLD_CYC = (VIEW_P + int'(WCNT_FULL) * (BLINK_P + 1)) * TICK_P;

    kb_support #(
        .TICK_CYCLES_P    (TICK_P),
        .VIEW_MS_P        (VIEW_P),
        .BLINK_MS_P       (BLINK_P),
        .REPEAT_HALF_MS_P (RPT_P),
        .CLICK_CYCLES_P   (CLICK_P),
        .BELL_MS_P        (BELL_P),
        .POWERUP_MS_P     (PU_P)
    ) dut_u (
        .ref_clk_i           (ref_clk),
        .srst_i              (srst),
        .raw_key_strobe_i    (pins[PIN_RAW]),
        .repeat_key_n_i      (pins[PIN_RPT_N]),
        .view_key_press_i    (pins[PIN_VIEW]),
        .view_restart_n_i    (pins[PIN_RST_N]),
        .terminal_activity_i (act),
        .bell_request_n_i    (pins[PIN_BELL_N]),
        .ring_request_n_i    (pins[PIN_RING_N]),
        .home_key_press_i    (pins[PIN_HOME]),
        .key_strobe_out_o    (outs[0]),
        .view_lamp_n_o       (outs[1]),
        .hold_n_o            (outs[2]),
        .view_o              (outs[3]),
        .click_o             (outs[4]),
        .speaker_out_o       (outs[5]),
        .initial_o           (outs[6]),
        .home_n_o            (outs[7])
    );

    kb_far_side far_u (
        .ref_clk_i     (ref_clk),
        .view_lamp_n_i (outs[1]),
        .speaker_i     (outs[5]),
        .key_strobe_i  (outs[0]),
        .click_i       (outs[4]),
        .pins_o        (pins),
        .act_o         (act)
    );

    // ------------------------------------------------------------
    // clock and shared helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wait_for(input int which, input logic val, input int max, output int n);
        n = 0;
        while (outs[which] !== val && n < max) begin
            @(negedge ref_clk);
            n++;
        end
        if (outs[which] !== val) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, outs[which], val);
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power();
        int n;
        check(outs[6], 1'b1);
        check(outs[7], 1'b0);
        wait_for(6, 1'b0, 200, n);
        check_range(n, 40, 80);
        check(outs[7], 1'b1);
        far_u.set_pin(PIN_HOME, 1'b1);
        wait_for(7, 1'b0, 10, n);
        far_u.set_pin(PIN_HOME, 1'b0);
        wait_for(7, 1'b1, 10, n);
    endtask

    task automatic t_view(input int kind);
        int n1;
        int n2;
        if (kind == 0) far_u.set_act(1'b1);
        if (kind == 1) far_u.set_pin(PIN_VIEW, 1'b1);
        if (kind == 2) far_u.set_pin(PIN_RST_N, 1'b0);
        far_u.set_act(1'b0);
        far_u.set_pin(PIN_VIEW, 1'b0);
        far_u.set_pin(PIN_RST_N, 1'b1);
        wait_for(2, 1'b1, 10, n1);
        cycles(1);
        far_u.clear_counts();
        wait_for(1, 1'b0, 1200, n1);
        check_range(n1, 190, 280);
        wait_for(2, 1'b0, 1200, n2);
        check_range(n1 + n2, HOLD_CYC - 3 * TICK_P, HOLD_CYC + TICK_P);
        check(far_u.lamp_blinks, 7);
        check(outs[3], 1'b1);
        cycles(150);
        check(outs[1], 1'b0);
        check(outs[2], 1'b0);
        check(far_u.lamp_blinks, 7);
    endtask

    task automatic t_strobe();
        int n;
        int bad;
        far_u.set_pin(PIN_RAW, 1'b1);
        wait_for(0, 1'b1, 10, n);
        check(outs[4], 1'b1);
        wait_for(4, 1'b0, 30, n);
        check_range(n, 10, 13);
        bad = 0;
        repeat (60) begin
            @(negedge ref_clk);
            if (outs[0] !== 1'b1) bad++;
        end
        check(bad, 0);
        far_u.set_pin(PIN_RAW, 1'b0);
        wait_for(0, 1'b0, 10, n);
    endtask

    task automatic t_repeat();
        far_u.set_pin(PIN_RPT_N, 1'b0);
        far_u.clear_counts();
        far_u.set_pin(PIN_RAW, 1'b1);
        cycles(400);
        check_range(far_u.strobe_falls, 4, 6);
        check_range(far_u.strobe_rises, 4, 6);
        check(far_u.click_rises, far_u.strobe_rises);
        far_u.set_pin(PIN_RAW, 1'b0);
        far_u.set_pin(PIN_RPT_N, 1'b1);
        cycles(20);
    endtask

    task automatic t_bell(input int idx);
        far_u.clear_counts();
        cycles(50);
        check(far_u.spk_edges, 0);
        far_u.set_pin(idx, 1'b0);
        cycles(300);
        check_range(far_u.spk_edges, 8, 13);
        check(outs[5], 1'b0);
        far_u.set_pin(idx, 1'b1);
        cycles(20);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors   = 0;
        compares = 0;
        srst     = 1'b1;
        cycles(6);
        srst = 1'b0;
        cycles(2);
        t_power();
        for (int k = 0; k < 3; k++) begin
            t_view(k);
        end
        t_strobe();
        t_repeat();
        t_bell(PIN_BELL_N);
        t_bell(PIN_RING_N);
        wrap_up();
    end
endmodule // kb_support_bench
